// ---- core/adc_ctl_regs.svh ----
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// register byte addresses
`define ADDR_CONV_CONTROL   32'h40050004
`define ADDR_CONV_STATUS    32'h40050008
`define ADDR_CONV_RESULT    32'h4005000C
`define ADDR_GAIN_COEF      32'h40050010
`define ADDR_OFFSET_COEF    32'h40050014
`define ADDR_IRQ_STATUS     32'h40050018
`define ADDR_IRQ_MASK       32'h4005001C

// control field positions
`define CTL_START_BIT       0
`define CTL_TRIG_LSB        1
`define CTL_TRIG_MSB        3
`define CTL_DISABLE_BIT     4
`define CTL_IRQ_EN_BIT      5
`define CTL_DMA_EN_BIT      6
`define CTL_REFBUF_OFF_BIT  7

// result field positions
`define RES_LSB             2
`define RES_MSB             13

// interrupt event bits
`define EVT_RESULT_BIT      0
`define EVT_OVERRUN_BIT     1

// reset values
`define RST_CONV_CONTROL    8'h90
`define RST_CONV_RESULT     16'h0000
`define RST_COEF            16'h0000
`define RST_IRQ_MASK        2'h0

// bus answers
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ---- core/adc_ctl_pkg.sv ----
package adc_ctl_pkg;

   // trigger source codes in the control register
   typedef enum logic [2:0] {
      TRIG_SOFT   = 3'b000,
      TRIG_CONTINUOUS_TRIGGER   = 3'b001,
      TRIG_T0_OVF = 3'b011,
      TRIG_T1_OVF = 3'b100,
      TRIG_PIN    = 3'b101
   } trig_mode_t;

   // converter sequencing
   typedef enum logic [0:0] {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;

endpackage : adc_ctl_pkg

// ---- core/adc_trigger_status_result.sv ----
// Behaviour
// - control bit 4 low powers converter on
// - bits 3:1 pick trigger source
// - writing start 1 in software mode converts
// - start bit stays set after conversion
// - status bit 0 flags result ready
// - reading result clears the ready flag
// - result interrupt needs the enable bit set; overrun does not
// - result sits in bits 13:2, rest zero
// - gain register holds written value
// - offset register holds written value
// - interrupt on every result while enabled
// - ready clears on read, power-down, reset
// - bit 6 enables a transfer request per result
// - coefficients never alter the result
`timescale 1ns/1ps
`include "adc_ctl_regs.svh"

module adc_trigger_status_result #(
   parameter int RES_W = 12              // converter resolution
) (
   input  wire logic             CLK_I,
   input  wire logic             RST_N_I,
   // AXI4-Lite write address
   input  wire logic [31:0]      AWADDR_I,
   input  wire logic             AWVALID_I,
   output logic                  AWREADY_O,
   // AXI4-Lite write data
   input  wire logic [31:0]      WDATA_I,
   input  wire logic [3:0]       WSTRB_I,
   input  wire logic             WVALID_I,
   output logic                  WREADY_O,
   // AXI4-Lite write response
   output logic [1:0]            BRESP_O,
   output logic                  BVALID_O,
   input  wire logic             BREADY_I,
   // AXI4-Lite read address
   input  wire logic [31:0]      ARADDR_I,
   input  wire logic             ARVALID_I,
   output logic                  ARREADY_O,
   // AXI4-Lite read data
   output logic [31:0]           RDATA_O,
   output logic [1:0]            RRESP_O,
   output logic                  RVALID_O,
   input  wire logic             RREADY_I,
   // trigger sources
   input  wire logic             TIMER0_OVF_I,
   input  wire logic             TIMER1_OVF_I,
   input  wire logic             EXT_TRIG_PIN_I,
   // analog converter core
   output logic                  CONV_POWER_DOWN_O,
   output logic                  REF_BUF_OFF_O,
   output logic                  CONV_START_O,
   input  wire logic             CONV_DONE_I,
   input  wire logic [RES_W-1:0] CONV_DATA_I,
   // system side
   output logic                  DMA_REQ_O,
   output logic                  IRQ_O
);

   // word-aligned address match
   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] base);
      hit = (a[31:2] == base[31:2]);
   endfunction : hit

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] m;                     // byte enables spread to bits
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   // register state
   logic [7:0]       control_r;       // control register
   logic             ready_r;         // result-ready flag
   logic [RES_W-1:0] result_r;        // last conversion value
   logic [15:0]      gain_r;          // gain coefficient
   logic [15:0]      offset_r;        // offset coefficient
   logic [1:0]       irq_stat_r;      // sticky event bits
   logic [1:0]       irq_mask_r;      // event mask

   // bus state
   logic             aw_held_r;       // address taken, data pending
   logic [31:0]      aw_addr_r;       // held write address
   logic             w_held_r;        // data taken, address pending
   logic [31:0]      w_data_r;        // held write data
   logic [3:0]       w_strb_r;        // held byte enables
   logic             bvalid_r;        // write answer pending
   logic [1:0]       bresp_r;         // write answer code
   logic             rvalid_r;        // read answer pending
   logic [1:0]       rresp_r;         // read answer code
   logic [31:0]      rdata_r;         // read answer data

   // converter sequencing state
   adc_ctl_pkg::conv_state_t conv_st_r;
   logic             pend_r;          // trigger waiting for idle
   logic             start_r;         // start strobe to converter
   logic             dma_r;           // transfer request strobe

   // pin synchroniser and edge detect
   logic             pin_s1_r;        // first stage, read by s2 only
   logic             pin_s2_r;        // second stage
   logic             pin_d_r;         // delayed for edge detect

   // write channel decoding
   wire aw_fire  = AWVALID_I & AWREADY_O;
   wire w_fire   = WVALID_I & WREADY_O;
   wire aw_have  = aw_held_r | aw_fire;
   wire w_have   = w_held_r | w_fire;
   wire wr_fire  = aw_have & w_have;
   wire [31:0] wa = aw_held_r ? aw_addr_r : AWADDR_I;
   wire [31:0] wd = w_held_r ? w_data_r : WDATA_I;
   wire [3:0]  ws = w_held_r ? w_strb_r : WSTRB_I;

   // write target selects
   wire wr_ctl   = wr_fire & hit(wa, `ADDR_CONV_CONTROL);
   wire wr_gain  = wr_fire & hit(wa, `ADDR_GAIN_COEF);
   wire wr_off   = wr_fire & hit(wa, `ADDR_OFFSET_COEF);
   wire wr_istat = wr_fire & hit(wa, `ADDR_IRQ_STATUS);
   wire wr_imask = wr_fire & hit(wa, `ADDR_IRQ_MASK);
   // read-only registers answer a write with okay and ignore it
   wire wr_ro    = hit(wa, `ADDR_CONV_STATUS)
                 | hit(wa, `ADDR_CONV_RESULT);
   wire wr_known = wr_ctl | wr_gain | wr_off | wr_istat | wr_imask
                 | (wr_fire & wr_ro);

   // merged write values
   wire [31:0] ctl_m  = merge({24'h000000, control_r}, wd, ws);
   wire [31:0] gain_m = merge({16'h0000, gain_r}, wd, ws);
   wire [31:0] off_m  = merge({16'h0000, offset_r}, wd, ws);
   wire [31:0] msk_m  = merge({30'h00000000, irq_mask_r}, wd, ws);
   // clear pattern honours byte lane 0 only
   wire [1:0]  istat_clr = (wr_istat & ws[0]) ? wd[1:0] : 2'h0;

   // read channel decoding
   wire ar_fire  = ARVALID_I & ARREADY_O;
   wire rd_ctl   = hit(ARADDR_I, `ADDR_CONV_CONTROL);
   wire rd_sta   = hit(ARADDR_I, `ADDR_CONV_STATUS);
   wire rd_res   = hit(ARADDR_I, `ADDR_CONV_RESULT);
   wire rd_gain  = hit(ARADDR_I, `ADDR_GAIN_COEF);
   wire rd_off   = hit(ARADDR_I, `ADDR_OFFSET_COEF);
   wire rd_istat = hit(ARADDR_I, `ADDR_IRQ_STATUS);
   wire rd_imask = hit(ARADDR_I, `ADDR_IRQ_MASK);
   wire rd_known = rd_ctl | rd_sta | rd_res | rd_gain | rd_off
                 | rd_istat | rd_imask;
   wire res_read = ar_fire & rd_res;

   // result word: data in 13:2, spare bits zero
   wire [15:0] res_word = {2'h0, result_r, 2'h0};

   // read data selection
   wire [31:0] rd_mux =
        rd_ctl   ? {24'h000000, control_r}
      : rd_sta   ? {31'h00000000, ready_r}
      : rd_res   ? {16'h0000, res_word}
      : rd_gain  ? {16'h0000, gain_r}
      : rd_off   ? {16'h0000, offset_r}
      : rd_istat ? {30'h00000000, irq_stat_r}
      : rd_imask ? {30'h00000000, irq_mask_r}
      : 32'h00000000;

   // control fields from the current register; ctl_nxt, the value about to take effect, feeds only the software start
   wire [7:0] ctl_nxt  = wr_ctl ? ctl_m[7:0] : control_r;
   wire conv_on        = ~control_r[`CTL_DISABLE_BIT];
   wire irq_en         = control_r[`CTL_IRQ_EN_BIT];
   wire dma_en         = control_r[`CTL_DMA_EN_BIT];
   wire [2:0] mode     = control_r[`CTL_TRIG_MSB:`CTL_TRIG_LSB];

   // software start: a one written while soft mode is chosen
   wire sw_start = wr_ctl & ws[0]
                 & ctl_nxt[`CTL_START_BIT]
                 & ~ctl_nxt[`CTL_DISABLE_BIT]
                 & (ctl_nxt[`CTL_TRIG_MSB:`CTL_TRIG_LSB]
                    == adc_ctl_pkg::TRIG_SOFT);

   // pin rising edge after synchronising
   wire pin_rise = pin_s2_r & ~pin_d_r;

   // trigger selection; other codes give nothing
   logic trig_hw;
   always_comb
   begin
      trig_hw = 1'b0;
      unique case (mode)
         adc_ctl_pkg::TRIG_CONTINUOUS_TRIGGER:   trig_hw = 1'b1;
         adc_ctl_pkg::TRIG_T0_OVF: trig_hw = TIMER0_OVF_I;
         adc_ctl_pkg::TRIG_T1_OVF: trig_hw = TIMER1_OVF_I;
         adc_ctl_pkg::TRIG_PIN:    trig_hw = pin_rise;
         default:                  trig_hw = 1'b0;
      endcase
   end

   // a hardware trigger counts only while powered on
   wire trig_req = sw_start | (trig_hw & conv_on);
   wire conv_idle = (conv_st_r == adc_ctl_pkg::CONV_IDLE);
   wire go        = conv_on & conv_idle & (pend_r | trig_req);
   // done only counts for a conversion that is running
   wire done      = CONV_DONE_I & ~conv_idle & conv_on;

   // bus handshake outputs
   assign AWREADY_O = ~aw_held_r & ~bvalid_r;
   assign WREADY_O  = ~w_held_r & ~bvalid_r;
   assign ARREADY_O = ~rvalid_r;
   assign BVALID_O  = bvalid_r;
   assign BRESP_O   = bresp_r;
   assign RVALID_O  = rvalid_r;
   assign RRESP_O   = rresp_r;
   assign RDATA_O   = rdata_r;

   // converter and system outputs
   assign CONV_POWER_DOWN_O = control_r[`CTL_DISABLE_BIT];
   assign REF_BUF_OFF_O     = control_r[`CTL_REFBUF_OFF_BIT];
   assign CONV_START_O      = start_r;
   assign DMA_REQ_O         = dma_r;
   assign IRQ_O             = |(irq_stat_r & irq_mask_r);

   // write channel: hold whichever half arrives first
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 32'h00000000;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
      end
      else
      begin
         // a lone half waits here; both halves commit together
         aw_held_r <= aw_have & ~wr_fire;
         w_held_r  <= w_have & ~wr_fire;
         // capture is harmless on commit, the held flags drop
         if (aw_fire)
            aw_addr_r <= AWADDR_I;
         if (w_fire)
         begin
            w_data_r <= WDATA_I;
            w_strb_r <= WSTRB_I;
         end
         // answer stands until the master takes it
         if (wr_fire)
            bresp_r <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         bvalid_r <= wr_fire | (bvalid_r & ~BREADY_I);
      end
   end

   // read channel: one cycle from address to data
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= `RESP_OKAY;
         rdata_r  <= 32'h00000000;
      end
      else if (ar_fire)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         rdata_r  <= rd_mux;
      end
      else if (rvalid_r && RREADY_I)
      begin
         rvalid_r <= 1'b0;
      end
   end

   // software-owned registers; start bit only moves by a write
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         control_r  <= `RST_CONV_CONTROL;
         gain_r     <= `RST_COEF;
         offset_r   <= `RST_COEF;
         irq_mask_r <= `RST_IRQ_MASK;
      end
      else
      begin
         if (wr_ctl) control_r <= ctl_m[7:0];
         if (wr_gain) gain_r <= gain_m[15:0];
         if (wr_off) offset_r <= off_m[15:0];
         if (wr_imask) irq_mask_r <= msk_m[1:0];
      end
   end

   // conversion sequencing; power-down aborts
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         conv_st_r <= adc_ctl_pkg::CONV_IDLE;
         pend_r    <= 1'b0;
         start_r   <= 1'b0;
      end
      else if (!conv_on)
      begin
         // triggers dropped while off; a start that powers on waits
         conv_st_r <= adc_ctl_pkg::CONV_IDLE;
         pend_r    <= sw_start;
         start_r   <= 1'b0;
      end
      else
      begin
         start_r <= go;
         unique case (conv_st_r)
            adc_ctl_pkg::CONV_IDLE:
               if (go) conv_st_r <= adc_ctl_pkg::CONV_BUSY;
            adc_ctl_pkg::CONV_BUSY:
               if (done) conv_st_r <= adc_ctl_pkg::CONV_IDLE;
         endcase
         // one trigger may queue behind a running one
         pend_r <= ~conv_idle & (pend_r | trig_req);
      end
   end

   // result, ready, sticky events, transfer request, pin stages
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         result_r   <= RES_W'(`RST_CONV_RESULT);
         ready_r    <= 1'b0;
         dma_r      <= 1'b0;
         irq_stat_r <= 2'h0;
         pin_s1_r   <= 1'b0;
         pin_s2_r   <= 1'b0;
         pin_d_r    <= 1'b0;
      end
      else
      begin
         // pin passes two stages before the edge detect reads it
         pin_s1_r <= EXT_TRIG_PIN_I;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
         dma_r    <= done & dma_en;
         if (done)
            result_r <= CONV_DATA_I;
         // a new result beats a same-cycle read
         ready_r  <= done | (ready_r & ~res_read & conv_on);
         // every result while enabled, even if ready; set wins
         irq_stat_r[`EVT_RESULT_BIT] <=
            (done & irq_en)
            | (irq_stat_r[`EVT_RESULT_BIT]
               & ~istat_clr[`EVT_RESULT_BIT]);
         // result landed on an unread one
         irq_stat_r[`EVT_OVERRUN_BIT] <=
            (done & ready_r & ~res_read)
            | (irq_stat_r[`EVT_OVERRUN_BIT]
               & ~istat_clr[`EVT_OVERRUN_BIT]);
      end
   end

endmodule : adc_trigger_status_result

// ---- tb/adc_trigger_status_result_chk.sv ----
`timescale 1ns/1ps
module adc_trigger_status_result_chk (
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic [1:0]  BRESP_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic        CONV_POWER_DOWN_O,
   input wire logic        CONV_START_O,
   input wire logic        CONV_DONE_I,
   input wire logic        DMA_REQ_O,
   input wire logic        IRQ_O
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // a converter that stayed off over the trigger edge never starts
   off_no_start_a:
      assert property (CONV_POWER_DOWN_O && $past(CONV_POWER_DOWN_O)
         |-> !CONV_START_O) else $error("start while powered down");
   start_pulse_a:
      assert property (CONV_START_O |=> !CONV_START_O)
         else $error("start pulse longer than one cycle");
   dma_cause_a:
      assert property (DMA_REQ_O |-> $past(CONV_DONE_I))
         else $error("transfer request without a result");
   irq_cause_a:
      assert property ($rose(IRQ_O) |-> $past(CONV_DONE_I)
         || $rose(BVALID_O)) else $error("irq rose uncaused");
   wr_answer_a:
      assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
         |=> BVALID_O) else $error("write answer late");
   rd_answer_a:
      assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
         else $error("read answer late");
   b_hold_a:
      assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
         else $error("write answer dropped");
   r_hold_a:
      assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
         else $error("read data dropped");
   ar_block_a:
      assert property (RVALID_O |-> !ARREADY_O)
         else $error("read taken while answer pending");
   w_block_a:
      assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
         else $error("write taken while answer pending");
endmodule : adc_trigger_status_result_chk

bind adc_trigger_status_result adc_trigger_status_result_chk chk (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .AWVALID_I(AWVALID_I),
   .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
   .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
   .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
   .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
   .CONV_POWER_DOWN_O(CONV_POWER_DOWN_O), .CONV_START_O(CONV_START_O),
   .CONV_DONE_I(CONV_DONE_I), .DMA_REQ_O(DMA_REQ_O), .IRQ_O(IRQ_O)
);

// ---- tb/adc_trigger_status_result_tb.sv ----
`timescale 1ns/1ps
`include "adc_ctl_regs.svh"
module adc_trigger_status_result_tb;
   logic        clk = 1'b0, rst_n = 1'b0;      // core clock, reset
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        tmr0 = 0, tmr1 = 0, pin = 0, done = 0;  // trigger sources
   logic [11:0] cdata = '0;                     // converter sample
   logic        awready, wready, bvalid, arready, rvalid;
   logic        pwr_dn, refbuf, start, dma, irq;
   logic [1:0]  bresp, rresp, resp;             // last bus answer
   logic [31:0] rdata, rval;                    // last read word
   logic [11:0] d1, d2;                         // random samples
   logic [31:0] g;                              // random coefficient
   int          err_total = 0, n_checks = 0, n_start = 0, n_dma = 0;
   int          seed = 32'h587B, k, s0;

   adc_trigger_status_result dut (
      .CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
      .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
      .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .TIMER0_OVF_I(tmr0), .TIMER1_OVF_I(tmr1), .EXT_TRIG_PIN_I(pin),
      .CONV_POWER_DOWN_O(pwr_dn), .REF_BUF_OFF_O(refbuf),
      .CONV_START_O(start), .CONV_DONE_I(done), .CONV_DATA_I(cdata),
      .DMA_REQ_O(dma), .IRQ_O(irq)
   );

   // 5 ns period
   always #2.5 clk = ~clk;

   // pulses counted mid-cycle, away from the launching edge
   always @(negedge clk)
   begin
      if (start === 1'b1) n_start++;
      if (dma === 1'b1) n_dma++;
   end

   task automatic stop_test;
      begin
         $display("checks %0d errors %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      begin
         n_checks++;
         if (seen !== exp)
         begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask : check

   // bounded handshake wait ran out
   task automatic hang;
      begin
         check("handshake", 32'h0, 32'h1);
         stop_test();
      end
   endtask : hang

   // bus write; bready raised a cycle late so the answer must stand
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge clk);
         awaddr  <= a;
         awvalid <= 1'b1;
         wdata   <= d;
         wvalid  <= 1'b1;
         for (n = 0; n < 40; n++)
         begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
         end
         if (n == 40) hang();
         resp = bresp;
         bready <= 1'b0;
      end
   endtask : wr

   // bus read, same late-ready habit
   task automatic rchk(input string w, input logic [31:0] a,
                       input logic [31:0] e);
      int n;
      begin
         @(posedge clk);
         araddr  <= a;
         arvalid <= 1'b1;
         for (n = 0; n < 40; n++)
         begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
         end
         if (n == 40) hang();
         rval = rdata;
         resp = rresp;
         rready <= 1'b0;
         check(w, rval, e);
      end
   endtask : rchk

   // converter finishes; stale data scrambled afterwards
   task automatic conv(input logic [11:0] d);
      begin
         @(posedge clk);
         cdata <= d;
         done  <= 1'b1;
         @(posedge clk);
         done  <= 1'b0;
         cdata <= ~d;
         @(posedge clk);
      end
   endtask : conv

   // one trigger source: 0 start bit, 1 timer0, 2 timer1, 3 pin
   task automatic fire(input int s, input logic [31:0] ctl);
      begin
         @(posedge clk);
         tmr0 <= (s == 1);
         tmr1 <= (s == 2);
         pin  <= (s == 3);
         @(posedge clk);
         tmr0 <= 1'b0;
         tmr1 <= 1'b0;
         if (s == 0) wr(`ADDR_CONV_CONTROL, ctl | 32'h1);
         repeat (4) @(posedge clk);
         pin <= 1'b0;
      end
   endtask : fire

   // does source s start a conversion in mode m
   function automatic logic want(input logic [2:0] m, input int s,
                                 input logic dis);
      begin
         return !dis && (m == adc_ctl_pkg::TRIG_CONTINUOUS_TRIGGER
            || (m == adc_ctl_pkg::TRIG_SOFT && s == 0)
            || (m == adc_ctl_pkg::TRIG_T0_OVF && s == 1)
            || (m == adc_ctl_pkg::TRIG_T1_OVF && s == 2)
            || (m == adc_ctl_pkg::TRIG_PIN && s == 3));
      end
   endfunction : want

   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      check("pwr_dn", pwr_dn, 1);
      check("refbuf", refbuf, 1);
      rchk("ctl", `ADDR_CONV_CONTROL, 32'h90);
      rchk("status", `ADDR_CONV_STATUS, 0);
      rchk("result", `ADDR_CONV_RESULT, 0);
      rchk("gain", `ADDR_GAIN_COEF, 0);
      rchk("offset", `ADDR_OFFSET_COEF, 0);
      g = $random(seed);
      wr(`ADDR_GAIN_COEF, g);
      rchk("gain", `ADDR_GAIN_COEF, {16'h0, g[15:0]});
      wr(`ADDR_OFFSET_COEF, ~g);
      rchk("offset", `ADDR_OFFSET_COEF, {16'h0, ~g[15:0]});
      wr(`ADDR_CONV_RESULT, g);
      check("ro_wresp", resp, 2'h0);
      rchk("result_ro", `ADDR_CONV_RESULT, 0);
      wr(32'h40050020, g);
      check("unmapped_w", resp, 2'h2);
      rchk("unmapped_r", 32'h40050020, 0);
      check("unmapped_rr", resp, 2'h2);
      // every code, every source, enabled and disabled
      for (k = 0; k < 64; k++)
      begin
         wr(`ADDR_CONV_CONTROL, 32'h10);
         s0 = n_start;
         wr(`ADDR_CONV_CONTROL, {27'h0, k[5], k[2:0], 1'b0});
         fire(k[4:3], {27'h0, k[5], k[2:0], 1'b0});
         repeat (6) @(posedge clk);
         check("started", n_start != s0, want(k[2:0], k[4:3], k[5]));
      end
      // soft start with irq and transfer requests on
      wr(`ADDR_IRQ_MASK, 32'h1);
      d1 = 12'($random(seed));
      d2 = 12'($random(seed));
      wr(`ADDR_CONV_CONTROL, 32'h10);
      wr(`ADDR_CONV_CONTROL, 32'h61);
      check("pwr_on", pwr_dn, 0);
      s0 = n_dma;
      conv(d1);
      check("dma", n_dma - s0, 1);
      check("irq", irq, 1);
      rchk("start_kept", `ADDR_CONV_CONTROL, 32'h61);
      wr(`ADDR_IRQ_STATUS, 32'h3);
      check("irq_clr", irq, 0);
      wr(`ADDR_CONV_CONTROL, 32'h61);
      conv(d2);
      check("irq_again", irq, 1);
      rchk("ready_held", `ADDR_CONV_STATUS, 1);
      rchk("result", `ADDR_CONV_RESULT, {18'h0, d2, 2'b00});
      rchk("ready_clr", `ADDR_CONV_STATUS, 0);
      wr(`ADDR_IRQ_MASK, 32'h0);
      check("irq_masked", irq, 0);
      wr(`ADDR_IRQ_STATUS, 32'h3);
      // interrupt enable off: no event, ready still set
      wr(`ADDR_IRQ_MASK, 32'h1);
      wr(`ADDR_CONV_CONTROL, 32'h01);
      conv(d1);
      check("irq_off", irq, 0);
      check("dma_off", n_dma - s0, 2);
      rchk("ready", `ADDR_CONV_STATUS, 1);
      wr(`ADDR_CONV_CONTROL, 32'h10);
      rchk("ready_pd", `ADDR_CONV_STATUS, 0);
      // start that powers on, then a reset after the result drops the ready flag
      wr(`ADDR_CONV_CONTROL, 32'h01);
      conv(d2);
      rchk("ready_pre", `ADDR_CONV_STATUS, 1);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk("ready_rst", `ADDR_CONV_STATUS, 0);
      rchk("ctl_rst", `ADDR_CONV_CONTROL, 32'h90);
      stop_test();
   end
endmodule : adc_trigger_status_result_tb
